/* hdl/conn_test_map.svh */
// Constants for the pin continuity check logic
`ifndef CONN_TEST_MAP_SVH
`define CONN_TEST_MAP_SVH
`define CT_MINTERM_COUNT 10
`define CT_DQ_WIDTH 16
`define CT_PERIOD_NS 100
`define CT_CLOCK_INPUT_ENABLE_NS 100
`define CT_REMAINING_INPUT_ENABLE_NS 200
`define CT_INPUT_OUTPUT_VALIDITY_NS 100
`define CT_CLOCK_INPUT_ENABLE_CYC \
	((`CT_CLOCK_INPUT_ENABLE_NS + `CT_PERIOD_NS - 1) / `CT_PERIOD_NS)
`define CT_REMAINING_INPUT_ENABLE_CYC \
	((`CT_REMAINING_INPUT_ENABLE_NS + `CT_PERIOD_NS - 1) / `CT_PERIOD_NS)
`define CT_INPUT_OUTPUT_VALIDITY_CYC \
	((`CT_INPUT_OUTPUT_VALIDITY_NS + `CT_PERIOD_NS - 1) / `CT_PERIOD_NS)
`define CT_VREF_HALF 8'h80
`endif

/* hdl/conn_test_pkg.sv */
// Types shared by both ends of the continuity check link
`include "conn_test_map.svh"
package conn_test_pkg;
	typedef logic [`CT_DQ_WIDTH-1:0] dq_word_t;
	typedef enum logic {width_x8, width_x16} dev_width_t;
	typedef enum {agent_idle, agent_enter, agent_settle, agent_sample,
		agent_done} agent_state_t;
endpackage

/* hdl/conn_test_if.sv */
// Pin-level carrier between tester and memory continuity logic
`timescale 1ns/1ps
interface conn_test_if;
	logic interconnect_check_enable_pin;
	logic cs_b;
	logic reset_b;
	logic [1:0] ba;
	logic [1:0] bg;
	logic [17:0] addr;
	logic cas_b;
	logic ras_b;
	logic we_b;
	logic cke;
	logic act_b;
	logic odt;
	logic ck_t;
	logic ck_c;
	logic par;
	logic alert_b;
	logic upper_byte_mask;
	logic lower_byte_mask;
	logic [15:0] dq_o;
	logic [15:0] dq_oe;
	logic [1:0] dqs_t_o;
	logic [1:0] dqs_c_o;
	logic dqs_oe;
	modport device (
		input interconnect_check_enable_pin, cs_b, reset_b, ba, bg, addr,
		input cas_b, ras_b, we_b, cke, act_b, odt, ck_t, ck_c, par,
		input alert_b, upper_byte_mask, lower_byte_mask,
		output dq_o, dq_oe, dqs_t_o, dqs_c_o, dqs_oe
	);
	modport agent (
		output interconnect_check_enable_pin, cs_b, reset_b, ba, bg, addr,
		output cas_b, ras_b, we_b, cke, act_b, odt, ck_t, ck_c, par,
		output alert_b, upper_byte_mask, lower_byte_mask,
		input dq_o, dq_oe, dqs_t_o, dqs_c_o, dqs_oe
	);
endinterface

/* hdl/conn_test_device.sv */
// Memory-side continuity check logic: minterms mapped onto DQ/DQS
`timescale 1ns/1ps
`include "conn_test_map.svh"
// Contract
// - Test mode follows enable pin level
// - Test mode bypasses normal memory function
// - Force DQ reference to half supply
// - Outputs enabled only while chip select low
// - Agent holds reset high during test
// - Parallel inputs, parallel outputs, no shifting
// - Minterms 0 to 3 XOR equations
// - Minterms 4 to 6 XOR equations
// - Minterm 7 differs for x16 and x8
// - Minterm 8, minterm 9 with reset-and-enable
// - x16: DQ0-9 minterms, DQ10-14 inverted copies of DQ2-6
// - Agent keeps CK_c complement of CK_t
// - Enter with reset, CKE, CS high
// - Other inputs sampled after enable interval
// - No refresh during test mode
// - Test mode only before initialization
// - Leaving test mode needs full reset
// - Outputs settle within validity interval
// - DQ/DQS are outputs; masks, alert, reset inputs
module conn_test_device
	import conn_test_pkg::*;
#(
	parameter dev_width_t WIDTH_MODE = width_x8
)
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	conn_test_if.device pins,
	input wire logic [15:0] normal_dq_in,
	input wire logic [15:0] normal_dq_oe_in,
	input wire logic refresh_req_in,
	output logic pin_continuity_check_mode_out,
	output logic refresh_allow_out,
	output logic [7:0] vref_dq_force_out,
	output logic vref_dq_force_en_out,
	output logic reset_needed_out
);
	logic [`CT_MINTERM_COUNT-1:0] mt;
	dq_word_t ct_dq;
	dq_word_t ct_oe;
	logic ct_mode;
	logic ct_dqs_t;
	logic ct_dqs_c;
	logic reset_needed_q;
	logic reset_needed_d;

	////////////////////////////////////////////////////////////////////////
	// Mode is the raw pin level; no clock so entry is asynchronous
	assign ct_mode = pins.interconnect_check_enable_pin;
	assign pin_continuity_check_mode_out = ct_mode;

	// Reference override only in test mode, nowhere else
	assign vref_dq_force_en_out = ct_mode;
	assign vref_dq_force_out = `CT_VREF_HALF;

	// Refresh requests blocked while testing, passed through otherwise
	assign refresh_allow_out = refresh_req_in & ~ct_mode;

	////////////////////////////////////////////////////////////////////////
	// Minterm equations; gates only, so result follows pins directly
	always_comb
	begin
		mt[0] = pins.addr[1] ^ pins.addr[6] ^ pins.par;
		mt[1] = pins.addr[8] ^ pins.alert_b ^ pins.addr[9];
		mt[2] = pins.addr[2] ^ pins.addr[5] ^ pins.addr[13];
		mt[3] = pins.addr[0] ^ pins.addr[7] ^ pins.addr[11];
		mt[4] = pins.ck_c ^ pins.odt ^ pins.cas_b;
		mt[5] = pins.cke ^ pins.ras_b ^ pins.addr[10];
		mt[6] = pins.act_b ^ pins.addr[4] ^ pins.ba[1];
		if (WIDTH_MODE == width_x16)
		begin
			mt[7] = pins.upper_byte_mask ^ pins.lower_byte_mask
				^ pins.ck_t;
		end
		else
		begin
			mt[7] = pins.bg[1] ^ pins.lower_byte_mask ^ pins.ck_t;
		end
		mt[8] = pins.we_b ^ pins.addr[12] ^ pins.ba[0];
		mt[9] = pins.bg[0] ^ pins.addr[3]
			^ (pins.reset_b & pins.interconnect_check_enable_pin);
	end

	////////////////////////////////////////////////////////////////////////
	// Output mapping per organisation, all bits in parallel
	always_comb
	begin
		ct_dq = '0;
		ct_oe = '0;
		ct_dqs_t = 1'b0;
		ct_dqs_c = 1'b0;
		if (WIDTH_MODE == width_x16)
		begin
			ct_dq[4:0] = mt[4:0];
			ct_dq[9:5] = mt[9:5];
			ct_dq[14:10] = ~ct_dq[6:2];
			ct_oe = 16'h7fff;
		end
		else
		begin
			ct_dq[7:0] = mt[7:0];
			ct_dqs_t = mt[8];
			ct_dqs_c = mt[9];
			ct_oe = 16'h00ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive: test results, or the normal path when not testing
	always_comb
	begin
		if (ct_mode)
		begin
			pins.dq_o = ct_dq;
			// Chip select gates the drivers; high leaves pins floating
			pins.dq_oe = pins.cs_b ? 16'h0000 : ct_oe;
			pins.dqs_t_o = {2{ct_dqs_t}};
			pins.dqs_c_o = {2{ct_dqs_c}};
			pins.dqs_oe = ~pins.cs_b &
				(WIDTH_MODE == width_x8);
		end
		else
		begin
			pins.dq_o = normal_dq_in;
			pins.dq_oe = normal_dq_oe_in;
			pins.dqs_t_o = 2'h0;
			pins.dqs_c_o = 2'h0;
			pins.dqs_oe = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky: once test mode is seen, state is unknown until reset
	always_comb
	begin
		reset_needed_d = reset_needed_q | ct_mode;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			reset_needed_q <= 1'b0;
		else if (clk_en_in)
			reset_needed_q <= reset_needed_d;
	end

	assign reset_needed_out = reset_needed_q;
endmodule

/* hdl/conn_test_agent.sv */
// Tester-side end: drives patterns, waits, captures results
`timescale 1ns/1ps
`include "conn_test_map.svh"
module conn_test_agent
	import conn_test_pkg::*;
#(
	parameter int CLK_EN_CYC = `CT_CLOCK_INPUT_ENABLE_CYC,
	parameter int ENABLE_CYC = `CT_REMAINING_INPUT_ENABLE_CYC,
	parameter int VALID_CYC = `CT_INPUT_OUTPUT_VALIDITY_CYC
)
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	conn_test_if.agent pins,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic [31:0] pattern_in,
	output logic busy_out,
	output logic result_valid_out,
	output logic [15:0] result_dq_out,
	output logic [1:0] result_dqs_out,
	output logic device_reset_req_out
);
	agent_state_t state_q;
	logic [7:0] count_q;
	logic [31:0] pat_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	logic [1:0] dqs_s1_q;
	logic [1:0] dqs_s2_q;
	logic [15:0] res_q;
	logic [1:0] res_dqs_q;
	logic valid_q;
	logic rst_req_q;
	logic en_q;
	logic cs_b_q;

	////////////////////////////////////////////////////////////////////////
	// Results come from another device: two flops before use
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			dqs_s1_q <= 2'h0;
			dqs_s2_q <= 2'h0;
		end
		else if (clk_en_in)
		begin
			dq_s1_q <= pins.dq_o;
			dq_s2_q <= dq_s1_q;
			dqs_s1_q <= pins.dqs_t_o;
			dqs_s2_q <= dqs_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer; pattern updates extend the settle wait by two sync flops
	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_q <= agent_idle;
			count_q <= 8'h00;
			pat_q <= 32'h0000_0000;
			en_q <= 1'b0;
			cs_b_q <= 1'b1;
			valid_q <= 1'b0;
			res_q <= 16'h0000;
			res_dqs_q <= 2'h0;
			rst_req_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			valid_q <= 1'b0;
			case (state_q)
				agent_idle:
				begin
					rst_req_q <= 1'b0;
					if (start_in)
					begin
						en_q <= 1'b1;
						cs_b_q <= 1'b1;
						pat_q <= pattern_in;
						count_q <= 8'(CLK_EN_CYC + ENABLE_CYC);
						state_q <= agent_enter;
					end
				end
				agent_enter:
				begin
					if (count_q == 8'h00)
					begin
						cs_b_q <= 1'b0;
						count_q <= 8'(VALID_CYC + 2);
						state_q <= agent_settle;
					end
					else
						count_q <= count_q - 8'h01;
				end
				agent_settle:
				begin
					if (count_q == 8'h00)
						state_q <= agent_sample;
					else
						count_q <= count_q - 8'h01;
				end
				agent_sample:
				begin
					res_q <= dq_s2_q;
					res_dqs_q <= dqs_s2_q;
					valid_q <= 1'b1;
					state_q <= agent_done;
				end
				agent_done:
				begin
					if (stop_in)
					begin
						en_q <= 1'b0;
						cs_b_q <= 1'b1;
						rst_req_q <= 1'b1;
						state_q <= agent_idle;
					end
					else if (start_in)
					begin
						pat_q <= pattern_in;
						count_q <= 8'(VALID_CYC + 2);
						state_q <= agent_settle;
					end
				end
				default:
					state_q <= agent_idle;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive; reset held high, CK_c locked to complement of CK_t
	assign pins.interconnect_check_enable_pin = en_q;
	assign pins.cs_b = cs_b_q;
	assign pins.reset_b = 1'b1;
	// CKE stays high until chip select opens the sampling window
	assign pins.cke = cs_b_q ? 1'b1 : pat_q[0];
	assign pins.ck_t = pat_q[1];
	assign pins.ck_c = ~pat_q[1];
	assign pins.addr = pat_q[19:2];
	assign pins.ba = pat_q[21:20];
	assign pins.bg = pat_q[23:22];
	assign pins.cas_b = pat_q[24];
	assign pins.ras_b = pat_q[25];
	assign pins.we_b = pat_q[26];
	assign pins.act_b = pat_q[27];
	assign pins.odt = pat_q[28];
	assign pins.par = pat_q[29];
	assign pins.alert_b = pat_q[30];
	assign pins.upper_byte_mask = pat_q[31];
	assign pins.lower_byte_mask = pat_q[0] ^ pat_q[31];

	assign busy_out = (state_q != agent_idle) && (state_q != agent_done);
	assign result_valid_out = valid_q;
	assign result_dq_out = res_q;
	assign result_dqs_out = res_dqs_q;
	assign device_reset_req_out = rst_req_q;
endmodule

/* tb/conn_test_asserts.sv */
// Concurrent checks on the wires of the continuity check link
`timescale 1ns/1ps
module conn_test_asserts (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic interconnect_check_enable_pin,
	input wire logic cs_b,
	input wire logic reset_b,
	input wire logic [1:0] ba,
	input wire logic [1:0] bg,
	input wire logic [17:0] addr,
	input wire logic cas_b,
	input wire logic ras_b,
	input wire logic we_b,
	input wire logic cke,
	input wire logic act_b,
	input wire logic odt,
	input wire logic ck_t,
	input wire logic ck_c,
	input wire logic par,
	input wire logic alert_b,
	input wire logic lower_byte_mask,
	input wire logic [15:0] dq_o,
	input wire logic [15:0] dq_oe,
	input wire logic [1:0] dqs_t_o,
	input wire logic [1:0] dqs_c_o,
	input wire logic dqs_oe
);
	// Mode and driving window; values only judged while outputs drive
	wire logic en = interconnect_check_enable_pin;
	wire logic live = en & ~cs_b;
	default clocking dc @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////////////////////////////
	// Output enables against chip select
	chk_cs_high_hiz: assert property (
		en && cs_b |-> dq_oe == 16'h0000 && !dqs_oe)
		else $error("Outputs driven with chip select high");
	chk_cs_low_drive: assert property (
		live |-> dq_oe == 16'h00ff && dqs_oe)
		else $error("Wrong output enables in test mode");
	// Minterm equations, x8 lane order
	chk_mt_low: assert property (
		live |-> dq_o[3:0] == {addr[0] ^ addr[7] ^ addr[11],
		addr[2] ^ addr[5] ^ addr[13], addr[8] ^ alert_b ^ addr[9],
		addr[1] ^ addr[6] ^ par})
		else $error("Minterms 0 to 3 wrong");
	chk_mt_mid: assert property (
		live |-> dq_o[6:4] == {act_b ^ addr[4] ^ ba[1],
		cke ^ ras_b ^ addr[10], ck_c ^ odt ^ cas_b})
		else $error("Minterms 4 to 6 wrong");
	chk_mt_seven: assert property (
		live |-> dq_o[7] == (bg[1] ^ lower_byte_mask ^ ck_t))
		else $error("Minterm 7 wrong");
	chk_mt_strobe: assert property (
		live |-> dqs_t_o == {2{we_b ^ addr[12] ^ ba[0]}} &&
		dqs_c_o == {2{bg[0] ^ addr[3] ^ (reset_b & en)}})
		else $error("Strobe minterms wrong");
	// Tester side obligations on entry and during the mode
	chk_clk_diff: assert property (
		en |-> ck_c != ck_t)
		else $error("Clock pair not complementary");
	chk_reset_held: assert property (
		en |-> reset_b)
		else $error("Reset low in test mode");
	chk_enter_quiet: assert property (
		$rose(en) |-> $past(cke) && $past(reset_b) && cs_b)
		else $error("Mode entered without quiet controls");
	chk_cke_quiet: assert property (
		en && cs_b |-> cke)
		else $error("Clock enable dropped before sampling window");
	chk_cs_wait: assert property (
		$rose(en) |-> cs_b [*3] ##[1:6] !cs_b)
		else $error("Chip select timing on entry wrong");
	cover property ($rose(en));
	cover property (live && dq_o[7]);
	cover property ($fell(en));
endmodule

/* tb/tb_top.sv */
// Bench joining the tester end and the memory end of the link
`timescale 1ns/1ps
`include "conn_test_map.svh"
module tb_top;
	import conn_test_pkg::*;
	logic core_clk_in, rst_b_in, clk_en, start, stop, refresh_req;
	logic [31:0] pattern;
	logic [15:0] normal_dq, normal_oe, res_dq;
	logic busy, res_valid, reset_req, test_mode, refresh_ok;
	logic vref_en, reset_needed;
	logic [1:0] res_dqs;
	logic [7:0] vref;
	int fails, checks;
	conn_test_if link();
	conn_test_device #(.WIDTH_MODE(width_x8)) u_conn_test_device (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
		.pins(link.device), .normal_dq_in(normal_dq),
		.normal_dq_oe_in(normal_oe), .refresh_req_in(refresh_req),
		.pin_continuity_check_mode_out(test_mode),
		.refresh_allow_out(refresh_ok), .vref_dq_force_out(vref),
		.vref_dq_force_en_out(vref_en), .reset_needed_out(reset_needed));
	conn_test_agent u_conn_test_agent (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
		.pins(link.agent), .start_in(start), .stop_in(stop),
		.pattern_in(pattern), .busy_out(busy), .result_valid_out(res_valid),
		.result_dq_out(res_dq), .result_dqs_out(res_dqs),
		.device_reset_req_out(reset_req));
	conn_test_asserts chk (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.interconnect_check_enable_pin(link.interconnect_check_enable_pin),
		.cs_b(link.cs_b), .reset_b(link.reset_b), .ba(link.ba), .bg(link.bg),
		.addr(link.addr), .cas_b(link.cas_b), .ras_b(link.ras_b),
		.we_b(link.we_b), .cke(link.cke), .act_b(link.act_b), .odt(link.odt),
		.ck_t(link.ck_t), .ck_c(link.ck_c), .par(link.par),
		.alert_b(link.alert_b), .lower_byte_mask(link.lower_byte_mask),
		.dq_o(link.dq_o), .dq_oe(link.dq_oe), .dqs_t_o(link.dqs_t_o),
		.dqs_c_o(link.dqs_c_o), .dqs_oe(link.dqs_oe));
	////////////////////////////////////////////////////////////////
	// Helpers; inputs always change at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Expected minterms 9..0 from the tester's pin map of a pattern
	function automatic logic [9:0] minterms(input logic [31:0] p);
		return {~(p[22] ^ p[5]), p[26] ^ p[14] ^ p[20],
			p[23] ^ p[0] ^ p[31] ^ p[1], p[27] ^ p[6] ^ p[21],
			p[0] ^ p[25] ^ p[12], ~(p[1] ^ p[28] ^ p[24]),
			p[2] ^ p[9] ^ p[13], p[4] ^ p[7] ^ p[15],
			p[10] ^ p[30] ^ p[11], p[3] ^ p[8] ^ p[29]};
	endfunction
	////////////////////////////////////////////////////////////////
	// Normal path before any test mode entry
	task automatic test_idle();
		normal_dq = 16'h5a3c;
		normal_oe = 16'hf00f;
		refresh_req = 1'b1;
		cyc(1);
		check(test_mode, 1'b0);
		check({link.dq_oe, link.dq_o}, {normal_oe, normal_dq});
		check({refresh_ok, vref_en, reset_needed}, 3'h4);
		$display("idle test finished");
	endtask
	// One pattern; on entry also the quiet window before chip select
	task automatic run(input logic [31:0] p, input logic entry);
		int n = 0;
		logic [9:0] m;
		m = minterms(p);
		pattern = p;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		if (entry)
		begin
			check({test_mode, busy}, 2'h3);
			check({vref_en, vref}, {1'b1, `CT_VREF_HALF});
			check(refresh_ok, 1'b0);
			check({link.dqs_oe, link.dq_oe}, 17'h00000);
		end
		while (res_valid !== 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		check(n < 40, 1'b1);
		check(res_dq[7:0], m[7:0]);
		check(res_dqs, {2{m[8]}});
		check(link.dqs_c_o, {2{m[9]}});
		if (entry)
		begin
			check({link.dqs_oe, link.dq_oe}, 17'h100ff);
			$display("entry test finished");
		end
	endtask
	// Leaving the mode: normal path back, reset demanded until reset
	task automatic test_exit();
		stop = 1'b1;
		cyc(1);
		stop = 1'b0;
		check(reset_req, 1'b1);
		cyc(1);
		check({test_mode, reset_needed}, 2'h1);
		check(link.dq_o, normal_dq);
		rst_b_in = 1'b0;
		cyc(2);
		rst_b_in = 1'b1;
		check(reset_needed, 1'b0);
		$display("exit test finished");
	endtask
	////////////////////////////////////////////////////////////////
	// Free-running 10 MHz clock
	initial
	begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	// Hang guard, well beyond the few hundred cycles the tests need
	initial
	begin
		#(2000 * 100);
		fails++;
		report_and_stop();
	end
	// Main sequence
	initial
	begin
		rst_b_in = 1'b0;
		clk_en = 1'b1;
		start = 1'b0;
		stop = 1'b0;
		pattern = 32'h0;
		refresh_req = 1'b0;
		normal_dq = 16'h0;
		normal_oe = 16'h0;
		cyc(16);
		rst_b_in = 1'b1;
		test_idle();
		run(32'h0, 1'b1);
		// Walking one reaches every pattern-driven minterm input through restarts; reset and enable stay high
		for (int i = 0; i < 32; i++)
			run(32'h1 << i, 1'b0);
		$display("walk test finished");
		test_exit();
		report_and_stop();
	end
endmodule
